// >>> core/cib_pkg.sv
package cib_pkg;
  // Bus positions: seven programmed channels plus two DMA controllers
  localparam int NPOS = 9;
  localparam int NPUL = 12;
  // Fixed 3-out-of-6 code per bus position, logical (active-high) form
  localparam logic [5:0] POS_CODE [NPOS] = '{6'h07, 6'h0B, 6'h0D, 6'h0E, 6'h13,
                                             6'h15, 6'h16, 6'h19, 6'h1A};
  // Control pulse numbers, one lead each
  localparam logic [3:0] P_WRITE_CONTROL_ADDRESS = 4'h0;
  localparam logic [3:0] P_WRITE_DATA = 4'h1;
  localparam logic [3:0] P_READ_DATA = 4'h2;
  localparam logic [3:0] P_READ_STATUS = 4'h3;
  localparam logic [3:0] P_IDLE_SEQ = 4'h4;
  localparam logic [3:0] P_READ_SVC = 4'h5;
  localparam logic [3:0] P_READ_INT = 4'h6;
  localparam logic [3:0] P_CLEAR_ERR = 4'h7;
  localparam logic [3:0] P_INTERRUPT_ACK = 4'h8;
  localparam logic [3:0] P_ERR_ACK = 4'h9;
  localparam logic [3:0] P_SVC_ACK = 4'hA;
  localparam logic [3:0] P_SPARE = 4'hB;
  // Register byte offsets of the central control
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_RDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_ERR = 8'h10;
  localparam logic [7:0] REG_CCODE = 8'h14;
  localparam logic [7:0] REG_INTR = 8'h18;
  // Field positions
  localparam int CTRL_POS_LSB = 4;
  localparam int CTRL_ABORT = 8;
  localparam int ERR_FAULT = 0;
  localparam int ERR_ACK_NONE = 1;
  localparam int ERR_ACK_MULTI = 2;
  localparam int ERR_PARITY = 3;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_ERR = 4'h0;
  // Sequencing counts in mclk cycles
  localparam logic [3:0] ADDR_SETUP_CYC = 4'h2;
  localparam logic [3:0] PULSE_CYC = 4'h3;
  localparam logic [3:0] RESP_WAIT_CYC = 4'h8;
  localparam logic [3:0] RELEASE_CYC = 4'h6;

  // Odd parity bit per byte
  function automatic logic [3:0] odd_par(input logic [31:0] d);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 4; i++) begin
      p[i] = ~^d[8*i +: 8];
    end
    return p;
  endfunction
endpackage

// >>> core/cib_if.sv
`timescale 1ns/10ps
// All leads active low except the high-active data enables; the two data drivers are resolved here
interface cib_if;
  logic [11:0] cmd_n; // Control pulse leads
  logic [5:0] addr_n; // Channel address leads
  logic [5:0] ack_n; // Address check leads
  logic rdy_n; // Ready response
  logic ok_n; // Operation-ok response
  logic maint_n; // Maintenance response
  logic fault_n; // Channel fault line
  logic [15:0] intr_n; // Interrupt leads
  logic [31:0] cc_d_n, ch_d_n; // Data driven by each end
  logic [3:0] cc_p_n, ch_p_n; // Parity driven by each end
  logic cc_oe, ch_oe; // High while that end drives data
  logic [31:0] bus_d_n; // Resolved data leads
  logic [3:0] bus_p_n; // Resolved parity leads
  // Undriven leads float high, the inactive level
  assign bus_d_n = cc_oe ? cc_d_n : (ch_oe ? ch_d_n : 32'hFFFF_FFFF);
  assign bus_p_n = cc_oe ? cc_p_n : (ch_oe ? ch_p_n : 4'hF);
  modport central (output cmd_n, addr_n, cc_d_n, cc_p_n, cc_oe,
                   input ack_n, rdy_n, ok_n, maint_n, fault_n, intr_n, bus_d_n, bus_p_n);
  modport channel (input cmd_n, addr_n, bus_d_n, bus_p_n,
                   output ack_n, rdy_n, ok_n, maint_n, fault_n, intr_n, ch_d_n, ch_p_n, ch_oe);
endinterface

// >>> core/cib_channel.sv
`timescale 1ns/10ps
// Channel end: answers pulses addressed to its own position
module cib_channel import cib_pkg::*; #(
  parameter int POSITION = 0,
  parameter bit SERIAL = 1'b0
) (
  input wire logic mclk,
  input wire logic sys_rst,
  cib_if.channel bus,
  input wire logic [31:0] per_data,
  input wire logic per_data_valid,
  input wire logic [31:0] status_word,
  input wire logic [31:0] svc_word,
  input wire logic int_pending,
  input wire logic internal_fail,
  input wire logic per_error,
  input wire logic per_rc101,
  input wire logic ctl_take,
  output logic [31:0] ctl_word,
  output logic ctl_strobe,
  output logic [31:0] wr_word,
  output logic wr_strobe,
  output logic idle_strobe,
  output logic buf_full
);
  localparam logic [5:0] MY_CODE = POS_CODE[POSITION];
  logic [53:0] meta, syn; // Two-stage input synchroniser
  logic [11:0] cmd; // Pulses, logical form
  logic sel, cmd_any;
  logic [3:0] pul; // Lowest active pulse number
  logic active, seen, ctl_full, fault, err_flag, rc101, bad;
  logic [3:0] op;
  logic [31:0] buf_d;
  logic next_active, next_seen, next_ctl_full, next_fault, next_err_flag, next_rc101;
  logic next_buf_full, next_ctl_strobe, next_wr_strobe, next_idle_strobe;
  logic [3:0] next_op;
  logic [31:0] next_buf_d, next_ctl_word, next_wr_word, out_d;

  // Bus leads cross into mclk before use
  always_ff @(posedge mclk) begin
    meta <= {bus.cmd_n, bus.addr_n, bus.bus_d_n, bus.bus_p_n};
    syn <= meta;
  end

  // Decode of synchronised leads
  always_comb begin
    cmd = ~syn[53:42];
    sel = (~syn[41:36]) == MY_CODE;
    cmd_any = |cmd;
    pul = 4'h0;
    for (int i = NPUL - 1; i >= 0; i--) begin
      if (cmd[i]) begin
        pul = 4'(i);
      end
    end
    // The serial channel does not answer service request reads
    bad = SERIAL && (pul == P_READ_SVC || pul == P_SVC_ACK);
  end

  // Next-state of the channel sequencer
  always_comb begin
    next_active = active;
    next_op = op;
    next_seen = cmd_any;
    next_ctl_full = ctl_full & ~ctl_take;
    next_fault = fault;
    next_err_flag = err_flag | per_error;
    next_rc101 = rc101 | (SERIAL & per_rc101);
    next_buf_d = buf_d;
    next_buf_full = buf_full;
    next_ctl_word = ctl_word;
    next_wr_word = wr_word;
    next_ctl_strobe = 1'b0;
    next_wr_strobe = 1'b0;
    next_idle_strobe = 1'b0;
    // Peripheral data lands in the buffer when it is free
    if (per_data_valid && !buf_full) begin
      next_buf_d = per_data;
      next_buf_full = 1'b1;
    end
    if (sel && cmd_any && !seen && !bad) begin
      // New pulse for this position
      next_active = 1'b1;
      next_op = pul;
      unique case (pul)
        P_WRITE_CONTROL_ADDRESS: begin
          if (ctl_full) begin
            next_fault = 1'b1;
          end else begin
            next_ctl_word = ~syn[35:4];
            next_ctl_full = 1'b1;
            next_ctl_strobe = 1'b1;
            next_err_flag = per_error;
            next_rc101 = SERIAL & per_rc101;
          end
        end
        P_WRITE_DATA: begin
          next_wr_word = ~syn[35:4];
          next_wr_strobe = 1'b1;
        end
        P_IDLE_SEQ: begin
          // Reinitialise, but channel errors stay
          next_idle_strobe = 1'b1;
          next_ctl_full = 1'b0;
          next_buf_full = 1'b0;
        end
        P_CLEAR_ERR: next_fault = 1'b0;
        default: ;
      endcase
    end else if (active && !sel) begin
      // Deselect ends the answer; a read-data empties the buffer
      next_active = 1'b0;
      if (op == P_READ_DATA && buf_full) begin
        next_buf_full = 1'b0;
      end
    end
  end

  // Data returned for the latched pulse
  always_comb begin
    out_d = 32'h0000_0000;
    unique case (op)
      P_READ_DATA: out_d = buf_d;
      P_READ_STATUS: out_d = status_word;
      P_READ_SVC, P_SVC_ACK: out_d = svc_word;
      P_READ_INT: out_d = {31'h0000_0000, int_pending};
      P_INTERRUPT_ACK: out_d[POSITION] = int_pending;
      P_ERR_ACK: out_d[POSITION] = fault | internal_fail;
      default: out_d = 32'h0000_0000;
    endcase
  end

  // Registers and registered leads
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      active <= 1'b0;
      op <= 4'h0;
      seen <= 1'b0;
      ctl_full <= 1'b0;
      fault <= 1'b0;
      err_flag <= 1'b0;
      rc101 <= 1'b0;
      buf_d <= RST_WORD;
      buf_full <= 1'b0;
      ctl_word <= RST_WORD;
      wr_word <= RST_WORD;
      ctl_strobe <= 1'b0;
      wr_strobe <= 1'b0;
      idle_strobe <= 1'b0;
      bus.ack_n <= 6'h3F;
      bus.rdy_n <= 1'b1;
      bus.ok_n <= 1'b1;
      bus.maint_n <= 1'b1;
      bus.fault_n <= 1'b1;
      bus.intr_n <= 16'hFFFF;
      bus.ch_d_n <= 32'hFFFF_FFFF;
      bus.ch_p_n <= 4'hF;
      bus.ch_oe <= 1'b0;
    end else begin
      active <= next_active;
      op <= next_op;
      seen <= next_seen;
      ctl_full <= next_ctl_full;
      fault <= next_fault;
      err_flag <= next_err_flag;
      rc101 <= next_rc101;
      buf_d <= next_buf_d;
      buf_full <= next_buf_full;
      ctl_word <= next_ctl_word;
      wr_word <= next_wr_word;
      ctl_strobe <= next_ctl_strobe;
      wr_strobe <= next_wr_strobe;
      idle_strobe <= next_idle_strobe;
      // Echo own code while answering
      bus.ack_n <= active ? ~MY_CODE : 6'h3F;
      // Read data waits for a full buffer, all else is immediate
      bus.rdy_n <= ~(active && (op != P_READ_DATA || buf_full));
      bus.ok_n <= ~(active && !err_flag);
      bus.maint_n <= ~(active && rc101);
      bus.fault_n <= ~(fault | internal_fail);
      bus.intr_n <= ~(16'(int_pending) << POSITION);
      bus.ch_d_n <= ~out_d;
      bus.ch_p_n <= ~odd_par(out_d);
      bus.ch_oe <= active && op != P_WRITE_CONTROL_ADDRESS && op != P_WRITE_DATA;
    end
  end
endmodule

// >>> core/cib_central.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Central drives pulses, address, shared data leads
// - Channels return responses, interrupts, fault, check
// - Seven programmed channels plus two DMA controllers
// - Fixed 3-of-6 code selects one position
// - 32 data plus parity both directions
// - Odd parity per byte, whole word even
// - Failing channel asserts its fault line
// - Fault line sets error bit and interrupt
// - Selected channel echoes its own code back
// - No or multiple acknowledge flags an error
// - Ready sampled after read-data marks completion
// - Read-data ready waits for buffered data
// - Direct channels ready at once otherwise
// - DMA positions: repeat read-data until ready
// - Operation-ok flag reports peripheral error
// - Only central and DMA check data parity
// - Operation-ok goes to condition code and status bit only
// - Only serial channel drives maintenance response
// - Every bus lead is active low except the high-active data enables
// - Single pulses from twelve distinct commands
// - DMA controller runs four channels behind it
// - Write-control while full reports channel fault
// - Interrupt ack: channel n drives bit n
module cib_central import cib_pkg::*; (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic err_irq,
  cib_if.central bus
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_SEL = 5'b00010,
    S_PULSE = 5'b00100,
    S_CHECK = 5'b01000,
    S_REL = 5'b10000
  } cib_state_t;

  logic [61:0] meta, syn; // Two-stage synchroniser on all return leads
  logic [5:0] ack; // Synchronised acknowledge code
  logic rdy, ok, maint, fault;
  logic [15:0] intr;
  logic [31:0] rd_d;
  logic [3:0] rd_p;
  // Bus slave holding registers
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [1:0] next_bresp, next_rresp;
  logic next_bvalid, next_rvalid, wr_fire, rd_fire, wr_hit, rd_hit;
  logic [31:0] next_rdata, rd_word;
  // Sequencer state
  cib_state_t state, next_state;
  logic [3:0] cnt, next_cnt, pul, next_pul, pos, next_pos;
  logic again, next_again, busy;
  logic [15:0] retries, next_retries;
  logic [31:0] wdata_r, next_wdata_r, rdata_r, next_rdata_r;
  logic rdy_r, ok_r, maint_r, next_rdy_r, next_ok_r, next_maint_r;
  logic ccode, next_ccode;
  logic [3:0] err, next_err, err_set, err_clr;
  logic [5:0] code, next_code;
  logic [2:0] ones;
  logic is_read, is_write;
  logic [11:0] next_cmd_n;
  logic [5:0] next_addr_n;
  logic next_oe;

  // Return leads cross into mclk before any logic sees them
  always_ff @(posedge mclk) begin
    meta <= {bus.ack_n, bus.rdy_n, bus.ok_n, bus.maint_n, bus.fault_n,
             bus.intr_n, bus.bus_d_n, bus.bus_p_n};
    syn <= meta;
  end

  // Active-low leads turned to logical form
  always_comb begin
    ack = ~syn[61:56];
    rdy = ~syn[55];
    ok = ~syn[54];
    maint = ~syn[53];
    fault = ~syn[52];
    intr = ~syn[51:36];
    rd_d = ~syn[35:4];
    rd_p = ~syn[3:0];
    ones = 3'h0;
    for (int i = 0; i < 6; i++) begin
      ones = ones + 3'(ack[i]);
    end
  end

  // Bus slave: address and data taken in either order, one write at a time
  always_comb begin
    s_axi_awready = !aw_held;
    s_axi_wready = !w_held;
    s_axi_arready = !s_axi_rvalid;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
    end
    wr_hit = aw_addr == REG_CTRL || aw_addr == REG_WDATA || aw_addr == REG_ERR;
    wr_fire = aw_held && w_held && !s_axi_bvalid;
    if (wr_fire) begin
      // Unmapped or read-only offsets answer with SLVERR
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_hit ? 2'h0 : 2'h2;
    end
    rd_fire = s_axi_arvalid && !s_axi_rvalid;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      REG_CTRL: rd_word = {24'h00_0000, pos, pul};
      REG_WDATA: rd_word = wdata_r;
      REG_RDATA: rd_word = rdata_r;
      REG_STATUS: rd_word = {retries, 11'h000, again, maint_r, ok_r, rdy_r, busy};
      REG_ERR: rd_word = {28'h000_0000, err};
      REG_CCODE: rd_word = {31'h0000_0000, ccode};
      REG_INTR: rd_word = {16'h0000, intr};
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = rd_hit ? 2'h0 : 2'h2;
    end
  end

  // Sequencer: select, pulse, check the answer, release
  always_comb begin
    busy = state != S_IDLE;
    is_write = pul == P_WRITE_CONTROL_ADDRESS || pul == P_WRITE_DATA;
    is_read = !is_write && pul != P_IDLE_SEQ && pul != P_CLEAR_ERR && pul != P_SPARE;
    next_state = state;
    next_cnt = cnt;
    next_pul = pul;
    next_pos = pos;
    next_code = code;
    next_again = again;
    next_retries = retries;
    next_wdata_r = wdata_r;
    next_rdata_r = rdata_r;
    next_rdy_r = rdy_r;
    next_ok_r = ok_r;
    next_maint_r = maint_r;
    next_ccode = ccode;
    err_set = 4'h0;
    err_clr = 4'h0;
    err_set[ERR_FAULT] = fault;
    if (wr_fire && wr_hit) begin
      // Software writes steer the sequencer
      if (aw_addr == REG_WDATA) begin
        next_wdata_r = w_data;
      end
      if (aw_addr == REG_ERR) begin
        err_clr = w_data[3:0];
      end
      if (aw_addr == REG_CTRL && w_data[CTRL_ABORT]) begin
        next_again = 1'b0;
      end else if (aw_addr == REG_CTRL && !busy) begin
        // One pulse per start, read-data pulsed again until ready; unknown positions select nobody
        next_pul = w_data[3:0] < 4'(NPUL) ? w_data[3:0] : P_SPARE;
        next_pos = w_data[CTRL_POS_LSB +: 4];
        next_code = w_data[CTRL_POS_LSB +: 4] < 4'(NPOS) ?
                    POS_CODE[w_data[CTRL_POS_LSB +: 4]] : 6'h00;
        next_retries = 16'h0000;
        next_state = S_SEL;
        next_cnt = ADDR_SETUP_CYC - 4'h1;
      end
    end
    unique case (state)
      S_IDLE: ;
      S_SEL: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h0) begin
          next_state = S_PULSE;
          next_cnt = PULSE_CYC - 4'h1;
        end
      end
      S_PULSE: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h0) begin
          next_state = S_CHECK;
          next_cnt = RESP_WAIT_CYC - 4'h1;
        end
      end
      S_CHECK: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h0) begin
          // Acknowledge must be exactly the addressed code
          if (ones == 3'h0) begin
            err_set[ERR_ACK_NONE] = 1'b1;
          end else if (ack != code) begin
            err_set[ERR_ACK_MULTI] = 1'b1;
          end
          next_rdy_r = rdy;
          next_ok_r = ok;
          next_maint_r = maint;
          // Operation-ok only reaches the condition code and status bit, no check fires
          next_ccode = ok;
          if (is_read && rdy) begin
            next_rdata_r = rd_d;
            if (rd_p != odd_par(rd_d)) begin
              err_set[ERR_PARITY] = 1'b1;
            end
          end
          // A read-data without ready is pulsed again until it comes
          next_again = pul == P_READ_DATA && !rdy;
          if (pul == P_READ_DATA && !rdy) begin
            next_retries = retries + 16'h0001;
          end
          next_state = S_REL;
          next_cnt = RELEASE_CYC - 4'h1;
        end
      end
      S_REL: begin
        // Address released so the channel drops its answer
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h0) begin
          next_state = again ? S_SEL : S_IDLE;
          next_cnt = ADDR_SETUP_CYC - 4'h1;
        end
      end
    endcase
    // A fault arriving with its clear still sets
    next_err = (err & ~err_clr) | err_set;
    // Lead values for the next cycle, active low except the high-active data enable
    next_cmd_n = ~((next_state == S_PULSE) ? (12'h001 << next_pul) : 12'h000);
    next_addr_n = ~((next_state == S_IDLE || next_state == S_REL) ? 6'h00 : next_code);
    // Judged on the pulse about to run, so a read after a write never drives
    next_oe = (next_pul == P_WRITE_CONTROL_ADDRESS || next_pul == P_WRITE_DATA) &&
              (next_state == S_SEL || next_state == S_PULSE || next_state == S_CHECK);
  end

  // Registers of slave and sequencer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= RST_WORD;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= RST_WORD;
      state <= S_IDLE;
      cnt <= 4'h0;
      pul <= 4'h0;
      pos <= 4'h0;
      code <= 6'h00;
      again <= 1'b0;
      retries <= 16'h0000;
      wdata_r <= RST_WORD;
      rdata_r <= RST_WORD;
      rdy_r <= 1'b0;
      ok_r <= 1'b0;
      maint_r <= 1'b0;
      ccode <= 1'b0;
      err <= RST_ERR;
      err_irq <= 1'b0;
      bus.cmd_n <= 12'hFFF;
      bus.addr_n <= 6'h3F;
      bus.cc_d_n <= 32'hFFFF_FFFF;
      bus.cc_p_n <= 4'hF;
      bus.cc_oe <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      state <= next_state;
      cnt <= next_cnt;
      pul <= next_pul;
      pos <= next_pos;
      code <= next_code;
      again <= next_again;
      retries <= next_retries;
      wdata_r <= next_wdata_r;
      rdata_r <= next_rdata_r;
      rdy_r <= next_rdy_r;
      ok_r <= next_ok_r;
      maint_r <= next_maint_r;
      ccode <= next_ccode;
      err <= next_err;
      err_irq <= |next_err;
      bus.cmd_n <= next_cmd_n;
      bus.addr_n <= next_addr_n;
      bus.cc_d_n <= ~next_wdata_r;
      bus.cc_p_n <= ~odd_par(next_wdata_r);
      bus.cc_oe <= next_oe;
    end
  end
endmodule

// >>> sim/cib_asserts.sv
`timescale 1ns/10ps
// Watches the leads between the two ends
module cib_asserts import cib_pkg::*; #(
  parameter int POSITION = 2
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [11:0] cmd_n,
  input wire logic [5:0] addr_n,
  input wire logic [5:0] ack_n,
  input wire logic rdy_n,
  input wire logic cc_oe,
  input wire logic ch_oe,
  input wire logic [31:0] bus_d_n,
  input wire logic [3:0] bus_p_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // High while no pulse lead is low
  wire logic idle = &cmd_n;
  // Inverting nine bits flips odd parity to an even count
  logic par_ok;
  always_comb begin
    par_ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      par_ok = par_ok & ~^{bus_d_n[8*i +: 8], bus_p_n[i]};
    end
  end
  sequence pulse_s;
    !idle [*3] ##1 idle;
  endsequence
  sequence ack_up_s;
    ack_n != 6'h3F && $past(ack_n) == 6'h3F;
  endsequence
  one_pulse_a: assert property ($countones(~cmd_n) <= 1)
    else $error("several pulse leads low");
  pulse_len_a: assert property ($fell(idle) |-> pulse_s)
    else $error("pulse length wrong");
  addr_code_a: assert property (addr_n == 6'h3F || $countones(~addr_n) == 3)
    else $error("address not a 3-of-6 code");
  pulse_sel_a: assert property (!idle |-> addr_n != 6'h3F)
    else $error("pulse without address");
  data_par_a: assert property (cc_oe || ch_oe |-> par_ok)
    else $error("byte parity wrong");
  one_drv_a: assert property (!(cc_oe && ch_oe))
    else $error("both ends drive data");
  ack_echo_a: assert property (ack_up_s |-> ack_n == addr_n)
    else $error("acknowledge differs from address");
  ready_fast_a: assert property ($fell(idle) && addr_n == ~POS_CODE[POSITION]
    && cmd_n[P_READ_DATA] && cmd_n[P_READ_SVC] && cmd_n[P_SVC_ACK] |-> ##[1:8] !rdy_n)
    else $error("ready late");
endmodule

// >>> sim/channel_io_bus_interface_bench.sv
`timescale 1ns/10ps
// Central and channel ends joined; software side is an AXI4-Lite master
module channel_io_bus_interface_bench import cib_pkg::*;;
  logic mclk, sys_rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, per_data, status_word, rv;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic per_data_valid, int_pending, internal_fail, per_error, per_rc101, ctl_take, buf_full;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, err_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, ctl_word, wr_word;
  int fail_count, compares;
  cib_if bus_if ();
  cib_central cib_central_i (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .err_irq, .bus(bus_if));
  // Serial channel at position 2, so the maintenance lead can be seen
  cib_channel #(.POSITION(2), .SERIAL(1'b1)) cib_channel_i (.mclk, .sys_rst, .bus(bus_if),
    .per_data, .per_data_valid, .status_word, .svc_word(32'h0000_00F0), .int_pending,
    .internal_fail, .per_error, .per_rc101, .ctl_take, .ctl_word, .ctl_strobe(),
    .wr_word, .wr_strobe(), .idle_strobe(), .buf_full);
  cib_asserts #(.POSITION(2)) cib_asserts_i (.mclk, .sys_rst, .cmd_n(bus_if.cmd_n),
    .addr_n(bus_if.addr_n), .ack_n(bus_if.ack_n), .rdy_n(bus_if.rdy_n), .cc_oe(bus_if.cc_oe),
    .ch_oe(bus_if.ch_oe), .bus_d_n(bus_if.bus_d_n), .bus_p_n(bus_if.bus_p_n));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task finish_test;
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    // No count of its own: only the watchdog ends a wait for the answer
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge mclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Polls busy; a bounded count so a stuck sequence cannot hang here
  task idle_wait;
    for (int n = 0; n < 100; n++) begin
      rd(REG_STATUS, 2'h0);
      if (rv[0] === 1'b0) break;
    end
    chk({31'h0, rv[0]}, 32'h0);
  endtask
  task op(input logic [3:0] pos, input logic [3:0] p);
    wr(REG_CTRL, {24'h0, pos, p}, 2'h0);
    idle_wait;
  endtask
  task t_regs;
    rd(REG_ERR, 2'h0);
    chk(rv, 32'h0);
    rd(8'hFC, 2'h2);
    wr(REG_RDATA, 32'h1, 2'h2);
  endtask
  task t_status;
    status_word <= 32'hA5C3_1E0F;
    op(4'h2, P_READ_STATUS);
    rd(REG_RDATA, 2'h0);
    chk(rv, 32'hA5C3_1E0F);
    rd(REG_STATUS, 2'h0);
    chk({29'h0, rv[2:0]}, 32'h6);
    rd(REG_ERR, 2'h0);
    chk(rv, 32'h0);
  endtask
  task t_write;
    wr(REG_WDATA, 32'h3C5A_9612, 2'h0);
    op(4'h2, P_WRITE_DATA);
    chk(wr_word, 32'h3C5A_9612);
    op(4'h2, P_WRITE_CONTROL_ADDRESS);
    chk(ctl_word, 32'h3C5A_9612);
    // Control register still full, so a second write-control is a fault
    op(4'h2, P_WRITE_CONTROL_ADDRESS);
    rd(REG_ERR, 2'h0);
    chk(rv, 32'h1);
    ctl_take <= 1'b1;
    op(4'h2, P_CLEAR_ERR);
    ctl_take <= 1'b0;
    wr(REG_ERR, 32'hF, 2'h0);
  endtask
  // Read-data without peripheral data keeps the retry loop going
  task t_rdwait;
    wr(REG_CTRL, {24'h0, 4'h2, P_READ_DATA}, 2'h0);
    repeat (60) @(posedge mclk);
    rd(REG_STATUS, 2'h0);
    chk({31'h0, rv[4]}, 32'h1);
    per_data <= 32'h0F1E_2D3C;
    per_data_valid <= 1'b1;
    idle_wait;
    per_data_valid <= 1'b0;
    chk({31'h0, rv[1]}, 32'h1);
    rd(REG_RDATA, 2'h0);
    chk(rv, 32'h0F1E_2D3C);
    chk({31'h0, buf_full}, 32'h1);
  endtask
  // Empty position, then two pulses the serial channel ignores
  task t_noack;
    logic [7:0] c [3];
    c = '{{4'h0, P_READ_STATUS}, {4'h2, P_READ_SVC}, {4'h2, P_SVC_ACK}};
    foreach (c[i]) begin
      op(c[i][7:4], c[i][3:0]);
      rd(REG_ERR, 2'h0);
      chk(rv, 32'h2);
      chk({31'h0, err_irq}, 32'h1);
      wr(REG_ERR, 32'hF, 2'h0);
    end
  endtask
  task t_fault;
    internal_fail <= 1'b1;
    repeat (10) @(posedge mclk);
    rd(REG_ERR, 2'h0);
    chk(rv, 32'h1);
    chk({31'h0, err_irq}, 32'h1);
    internal_fail <= 1'b0;
    op(4'h2, P_CLEAR_ERR);
    wr(REG_ERR, 32'hF, 2'h0);
    rd(REG_ERR, 2'h0);
    chk({rv[31:1], err_irq}, 32'h0);
  endtask
  task t_flags;
    {per_error, per_rc101} <= 2'h3;
    op(4'h2, P_READ_STATUS);
    chk({31'h0, rv[3]}, 32'h1);
    rd(REG_CCODE, 2'h0);
    chk({31'h0, rv[0]}, 32'h0);
    rd(REG_ERR, 2'h0);
    chk(rv, 32'h0);
    {per_error, per_rc101} <= 2'h0;
  endtask
  task t_pulses;
    logic [3:0] p [3];
    p = '{P_IDLE_SEQ, P_READ_INT, P_ERR_ACK};
    int_pending <= 1'b1;
    foreach (p[i]) begin
      op(4'h2, p[i]);
      rd(REG_ERR, 2'h0);
      chk(rv, 32'h0);
    end
    chk({31'h0, buf_full}, 32'h0);
    op(4'h2, P_INTERRUPT_ACK);
    rd(REG_RDATA, 2'h0);
    chk({31'h0, rv[2]}, 32'h1);
    rd(REG_INTR, 2'h0);
    chk({31'h0, rv[2]}, 32'h1);
    int_pending <= 1'b0;
  endtask
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, per_data, status_word} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {per_data_valid, int_pending, internal_fail, per_error, per_rc101, ctl_take} = '0;
    fail_count = 0;
    compares = 0;
    sys_rst = 1'b1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs;
    t_status;
    t_write;
    t_rdwait;
    t_noack;
    t_fault;
    t_flags;
    t_pulses;
    finish_test;
  end
  // Whole run is under a thousand cycles; this limit of 20000 cycles cuts a hang short
  initial begin
    #400000;
    fail_count++;
    finish_test;
  end
endmodule
